// *** iss_defines.vh ***
/*
 Constants of the I2C slave status and address block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef ISS_DEFINES_VH
`define ISS_DEFINES_VH
// Register byte addresses (index times four)
`define ISS_IDX_SECOND_ADDR 8'h9E
`define ISS_IDX_STATUS 8'hEC
`define ISS_IDX_FIRST_ADDR 8'hED
`define ISS_IDX_DATA 8'hEE
`define ISS_ADDR_SECOND_ADDR 12'h278
`define ISS_ADDR_STATUS 12'h3B0
`define ISS_ADDR_FIRST_ADDR 12'h3B4
`define ISS_ADDR_DATA 12'h3B8
`define ISS_ADDR_IRQ_STATUS 12'h400
`define ISS_ADDR_IRQ_CLEAR 12'h404
`define ISS_ADDR_IRQ_ENABLE 12'h408
`define ISS_ADDR_CONTROL 12'h40C
// Status bit positions
`define ISS_BIT_WAKE 7
`define ISS_BIT_MATCH 6
`define ISS_BIT_STOP 5
`define ISS_BIT_RESTART 4
`define ISS_BIT_TXB 3
`define ISS_BIT_RXB 2
`define ISS_BIT_FIRST 1
`define ISS_BIT_NACK 0
// Address register fields
`define ISS_BIT_ENABLE 7
// Interrupt bits
`define ISS_IRQ_MATCH 0
`define ISS_IRQ_STOP 1
`define ISS_IRQ_RESTART 2
`define ISS_IRQ_TXB 3
`define ISS_IRQ_RXB 4
`define ISS_IRQ_NACK 5
`define ISS_IRQ_WIDTH 6
// Reset values
`define ISS_RESET_BYTE 8'h00
`endif

// *** iss_slave.v ***
/*
 I2C slave: status flags, dual address match, data register, APB slave.
 Assumes scl/sda pins asynchronous to pclk and much slower (pclk/8 or less).
*/
// Added by the designer: the APB register port.
// Overview of operation
// - First address match sets sticky bit 6
// - Match interrupt only when match enable set
// - STOP sets sticky bit 5
// - Repeated START sets sticky bit 4
// - Bit 3 ready for byte, data write clears
// - Bit 2 set on receive, read clears
// - Bit 1 marks first byte after match
// - Bit 0 set on master NACK
// - After NACK resend previous byte
// - Bit 7 wakeup flag, write one clears
// - Data read receive, write transmit, separate
// - Second address matches concurrently with first
// - Record which address matched
`timescale 1ns/10ps
`include "iss_defines.vh"
module iss_slave (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  output wire irq,
  output reg which_address_matched,
  output reg transmitting
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_ACK = 2'd3;

  reg scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  reg [1:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] first_address_reg, second_address_reg;
  reg [7:0] rx_data, tx_data, tx_shift;
  reg match_wakeup_flag, address_matched_flag, stop_seen_flag, restart_seen_flag;
  reg transmit_buffer_flag, receive_buffer_flag, first_byte_indicator, no_ack_flag;
  reg match_irq_enable, awaiting_first;
  reg [`ISS_IRQ_WIDTH-1:0] irq_status, irq_enable;
  reg got_nack, busy, ack_phase_addr;
  wire scl_rise, scl_fall, start_cond, stop_cond;
  wire match1, match2;
  wire wr_en, rd_en;
  wire [7:0] status_byte;
  wire [`ISS_IRQ_WIDTH-1:0] ev;
  // Events of this cycle
  reg ev_match, ev_rx, ev_txb, ev_nack, ev_ack;

  ////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers and edge detect on the synchronised copies
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
  // Never stretches the clock
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign sda_out = 1'b0;

  // Address comparators on the byte being completed
  // Address sits in bits 7:1, bit 0 is the direction bit
  assign match1 = first_address_reg[`ISS_BIT_ENABLE] &
                  (shift[7:1] == first_address_reg[6:0]);
  assign match2 = second_address_reg[`ISS_BIT_ENABLE] &
                  (shift[7:1] == second_address_reg[6:0]);

  ////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & penable & ~pwrite & clk_en;
  assign pslverr = psel & penable & ~(paddr == `ISS_ADDR_SECOND_ADDR ||
    paddr == `ISS_ADDR_STATUS || paddr == `ISS_ADDR_FIRST_ADDR ||
    paddr == `ISS_ADDR_DATA || paddr == `ISS_ADDR_IRQ_STATUS ||
    paddr == `ISS_ADDR_IRQ_CLEAR || paddr == `ISS_ADDR_IRQ_ENABLE ||
    paddr == `ISS_ADDR_CONTROL);
  assign status_byte = {match_wakeup_flag, address_matched_flag, stop_seen_flag,
    restart_seen_flag, transmit_buffer_flag, receive_buffer_flag,
    first_byte_indicator, no_ack_flag};

  // Read mux
  always @* begin
    prdata = 32'h00000000;
    case (paddr)
      `ISS_ADDR_SECOND_ADDR: prdata[7:0] = second_address_reg;
      `ISS_ADDR_STATUS: prdata[7:0] = status_byte;
      `ISS_ADDR_FIRST_ADDR: prdata[7:0] = first_address_reg;
      `ISS_ADDR_DATA: prdata[7:0] = rx_data;
      `ISS_ADDR_IRQ_STATUS: prdata[`ISS_IRQ_WIDTH-1:0] = irq_status;
      `ISS_ADDR_IRQ_ENABLE: prdata[`ISS_IRQ_WIDTH-1:0] = irq_enable;
      `ISS_ADDR_CONTROL: prdata[0] = match_irq_enable;
      default: prdata = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Byte engine: address phase, data phase, ack slot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= `ISS_RESET_BYTE;
      tx_shift <= `ISS_RESET_BYTE;
      sda_oe <= 1'b0;
      transmitting <= 1'b0;
      busy <= 1'b0;
      got_nack <= 1'b0;
      ack_phase_addr <= 1'b0;
      which_address_matched <= 1'b0;
      ev_match <= 1'b0;
      ev_rx <= 1'b0;
      ev_txb <= 1'b0;
      ev_nack <= 1'b0;
      ev_ack <= 1'b0;
    end else if (clk_en) begin
      ev_match <= 1'b0;
      ev_rx <= 1'b0;
      ev_txb <= 1'b0;
      ev_nack <= 1'b0;
      ev_ack <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        transmitting <= 1'b0;
        busy <= 1'b1;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        busy <= 1'b0;
        transmitting <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_DATA: begin
            if (scl_rise && !(state == ST_DATA && transmitting)) begin
              shift <= {shift[6:0], sda_s2};
            end
            if (scl_fall && state == ST_DATA && transmitting) begin
              sda_oe <= 1'b0;
            end
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && transmitting && bit_cnt != 4'h8 && state == ST_DATA) begin
              sda_oe <= ~tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
            if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              state <= ST_ACK;
              ack_phase_addr <= (state == ST_ADDR);
              if (state == ST_ADDR) begin
                if (match1 || match2) begin
                  ev_match <= 1'b1;
                  which_address_matched <= ~match1;
                  transmitting <= shift[0];
                  sda_oe <= 1'b1;
                end else begin
                  state <= ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (!transmitting) begin
                ev_rx <= 1'b1;
                sda_oe <= 1'b1;
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise && transmitting && !ack_phase_addr) begin
              got_nack <= sda_s2;
              ev_nack <= sda_s2;
              ev_ack <= ~sda_s2;
            end
            if (scl_fall) begin
              state <= ST_DATA;
              sda_oe <= 1'b0;
              if (transmitting) begin
                // Resend last byte after NACK or when no new byte was written, else load new one
                // Hazard: a resent MSB of zero holds SDA low and blocks a STOP
                if ((ack_phase_addr || !got_nack) && !transmit_buffer_flag) begin
                  tx_shift <= {tx_data[6:0], 1'b0};
                  sda_oe <= ~tx_data[7];
                  ev_txb <= 1'b1;
                end else begin
                  tx_shift <= {shift[6:0], 1'b0};
                  sda_oe <= ~shift[7];
                end
                shift <= (ack_phase_addr || !got_nack) && !transmit_buffer_flag ?
                  tx_data : shift;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers, data storage and sticky flags; set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_address_reg <= `ISS_RESET_BYTE;
      second_address_reg <= `ISS_RESET_BYTE;
      rx_data <= `ISS_RESET_BYTE;
      tx_data <= `ISS_RESET_BYTE;
      match_wakeup_flag <= 1'b0;
      address_matched_flag <= 1'b0;
      stop_seen_flag <= 1'b0;
      restart_seen_flag <= 1'b0;
      transmit_buffer_flag <= 1'b0;
      receive_buffer_flag <= 1'b0;
      first_byte_indicator <= 1'b0;
      no_ack_flag <= 1'b0;
      match_irq_enable <= 1'b0;
      awaiting_first <= 1'b0;
      irq_enable <= {`ISS_IRQ_WIDTH{1'b0}};
    end else if (clk_en) begin
      if (wr_en && paddr == `ISS_ADDR_FIRST_ADDR) first_address_reg <= pwdata[7:0];
      if (wr_en && paddr == `ISS_ADDR_SECOND_ADDR) second_address_reg <= pwdata[7:0];
      if (wr_en && paddr == `ISS_ADDR_IRQ_ENABLE) irq_enable <= pwdata[`ISS_IRQ_WIDTH-1:0];
      if (wr_en && paddr == `ISS_ADDR_CONTROL) match_irq_enable <= pwdata[0];
      if (wr_en && paddr == `ISS_ADDR_DATA) tx_data <= pwdata[7:0];
      if (ev_rx) rx_data <= shift;
      // Write-one clears on the status register
      if (wr_en && paddr == `ISS_ADDR_STATUS) begin
        if (pwdata[`ISS_BIT_WAKE]) match_wakeup_flag <= 1'b0;
        if (pwdata[`ISS_BIT_MATCH]) address_matched_flag <= 1'b0;
        if (pwdata[`ISS_BIT_STOP]) stop_seen_flag <= 1'b0;
        if (pwdata[`ISS_BIT_RESTART]) restart_seen_flag <= 1'b0;
        if (pwdata[`ISS_BIT_NACK]) no_ack_flag <= 1'b0;
      end
      if (ev_ack) no_ack_flag <= 1'b0;
      if (wr_en && paddr == `ISS_ADDR_DATA) transmit_buffer_flag <= 1'b0;
      if (rd_en && paddr == `ISS_ADDR_DATA) receive_buffer_flag <= 1'b0;
      // Hardware sets, placed last so they win
      if (ev_match) begin
        address_matched_flag <= 1'b1;
        match_wakeup_flag <= 1'b1;
        awaiting_first <= 1'b1;
      end
      // First byte after a match marks bit 1, the next byte clears it
      if (ev_rx) begin
        receive_buffer_flag <= 1'b1;
        first_byte_indicator <= awaiting_first;
        awaiting_first <= 1'b0;
      end
      if (stop_cond) stop_seen_flag <= 1'b1;
      if (start_cond && busy) restart_seen_flag <= 1'b1;
      if (ev_txb) transmit_buffer_flag <= 1'b1;
      if (ev_nack) no_ack_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write-one clear, enable gated
  assign ev = {ev_nack, ev_rx, ev_txb, start_cond & busy, stop_cond,
    ev_match & match_irq_enable};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= {`ISS_IRQ_WIDTH{1'b0}};
    end else if (clk_en) begin
      irq_status <= (irq_status & ~((wr_en && paddr == `ISS_ADDR_IRQ_CLEAR) ?
        pwdata[`ISS_IRQ_WIDTH-1:0] : {`ISS_IRQ_WIDTH{1'b0}})) | ev;
    end
  end
  assign irq = |(irq_status & irq_enable);
endmodule // iss_slave

// *** iss_slave_asserts.sv ***
/* Checker of iss_slave port behaviour.
   Bound into iss_slave; one pclk domain. */
`timescale 1ns/10ps
`include "iss_defines.vh"
module iss_slave_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scl_in,
  input wire scl_oe,
  input wire sda_out,
  input wire sda_oe,
  input wire irq
);
  wire acc = psel && penable;
  wire mapped = paddr inside {`ISS_ADDR_SECOND_ADDR, `ISS_ADDR_STATUS, `ISS_ADDR_FIRST_ADDR,
    `ISS_ADDR_DATA, `ISS_ADDR_IRQ_STATUS, `ISS_ADDR_IRQ_CLEAR, `ISS_ADDR_IRQ_ENABLE,
    `ISS_ADDR_CONTROL};
  wire addr_reg = paddr == `ISS_ADDR_FIRST_ADDR || paddr == `ISS_ADDR_SECOND_ADDR;
  reg [11:0] last_wa;
  reg [7:0] last_wd;
  ////////////////////
  // Remember the previous write for readback
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_wa <= 12'hFFF;
      last_wd <= 8'h00;
    end else if (acc) begin
      last_wa <= pwrite ? paddr : 12'hFFF;
      last_wd <= pwdata[7:0];
    end
  end
  ////////////////////
  // Port relations
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (acc |-> pready) else $error("pready low");
  a_err_unmapped: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  a_refused_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_addr_readback: assert property (acc && !pwrite && addr_reg && paddr == last_wa
    |-> prdata[7:0] == last_wd) else $error("address readback wrong");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !sda_oe)
    else $error("outputs active after reset");
  a_no_stretch: assert property (!scl_oe && !sda_out) else $error("scl driven");
  a_sda_on_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("sda moved with scl high");
  cover property (acc && pwrite && paddr == `ISS_ADDR_DATA);
  cover property ($rose(sda_oe));
  cover property (acc && pslverr);
  cover property ($rose(irq));
endmodule // iss_slave_chk
bind iss_slave iss_slave_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_in(scl_in), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .irq(irq));

// *** iss_master_model.sv ***
/* Behavioural I2C bus master, SCL period 800 ns.
   Assumes pull-ups; the slave pulls SDA low with sda_oe. */
`timescale 1ns/10ps
module iss_master_model (
  input wire sda_oe,
  output wire scl,
  output wire sda
);
  reg scl_o = 1'b1;
  reg sda_o = 1'b1;
  // Open-drain wires, released lines read high
  assign scl = scl_o;
  assign sda = sda_o && !sda_oe;
  // START or repeated START
  task start;
    begin
      // Step off the pclk edge that the bench returns on
      #10;
      sda_o = 1'b1;
      #200 scl_o = 1'b1;
      #200 sda_o = 1'b0;
      #200 scl_o = 1'b0;
      #200;
    end
  endtask
  // STOP, SCL then idles high
  task stop;
    begin
      #10;
      sda_o = 1'b0;
      #200 scl_o = 1'b1;
      #200 sda_o = 1'b1;
      #200;
    end
  endtask
  // Nine clocks, MSB first; o drives, i samples
  task xfer(input [8:0] o, output [8:0] i);
    integer k;
    begin
      #10;
      for (k = 8; k >= 0; k = k - 1) begin
        sda_o = o[k];
        #200 scl_o = 1'b1;
        #200 i[k] = sda;
        #200 scl_o = 1'b0;
        #200;
      end
    end
  endtask
endmodule // iss_master_model

// *** iss_slave_tb.sv ***
/* Self-checking bench of iss_slave over APB and I2C.
   Assumes the master model and checker files compiled first. */
`timescale 1ns/10ps
`include "iss_defines.vh"
module iss_slave_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rv;
  reg er;
  reg [8:0] bi;
  integer errors = 0;
  integer checks_done = 0;
  wire [31:0] prdata;
  wire pready, pslverr, scl, sda, sda_oe, irq, which_address_matched, transmitting;
  always #50 pclk = ~pclk;
  ////////////////////
  // Design and bus master
  iss_slave DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(), .scl_oe(), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .irq(irq), .which_address_matched(which_address_matched),
    .transmitting(transmitting));
  iss_master_model m (.sda_oe(sda_oe), .scl(scl), .sda(sda));
  ////////////////////
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // One APB transfer, waits for pready
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] mk, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rv & mk, e);
    end
  endtask
  task report_and_stop;
    begin
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  ////////////////////
  // Hang guard
  initial begin
    #1000000;
    errors = errors + 1;
    report_and_stop;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ISS_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    rd(`ISS_ADDR_FIRST_ADDR, 32'hFFFFFFFF, 32'h0);
    rd(`ISS_ADDR_SECOND_ADDR, 32'hFFFFFFFF, 32'h0);
    rd(`ISS_ADDR_DATA, 32'hFFFFFFFF, 32'h0);
    rd(12'h010, 32'hFFFFFFFF, 32'h0);
    chk(er, 1'b1);
    // Address disabled: no acknowledge
    apb(1'b1, `ISS_ADDR_FIRST_ADDR, 32'h25);
    m.start;
    m.xfer({7'h25, 2'b01}, bi);
    chk(bi[0], 1'b1);
    m.stop;
    apb(1'b1, `ISS_ADDR_FIRST_ADDR, 32'hA5);
    apb(1'b1, `ISS_ADDR_SECOND_ADDR, 32'hBA);
    rd(`ISS_ADDR_SECOND_ADDR, 32'hFF, 32'hBA);
    apb(1'b1, `ISS_ADDR_IRQ_ENABLE, 32'h11);
    // Write two bytes to the first address, match interrupt still off
    apb(1'b1, `ISS_ADDR_STATUS, 32'hF1);
    m.start;
    m.xfer({7'h25, 2'b01}, bi);
    chk(bi[0], 1'b0);
    m.xfer({8'h5A, 1'b1}, bi);
    rd(`ISS_ADDR_STATUS, 32'h77, 32'h46);
    chk(which_address_matched, 1'b0);
    chk(transmitting, 1'b0);
    rd(`ISS_ADDR_IRQ_STATUS, 32'h01, 32'h0);
    chk(irq, 1'b1);
    apb(1'b1, `ISS_ADDR_IRQ_CLEAR, 32'h3F);
    #1 chk(irq, 1'b0);
    rd(`ISS_ADDR_DATA, 32'hFF, 32'h5A);
    apb(1'b1, `ISS_ADDR_STATUS, 32'h0);
    rd(`ISS_ADDR_STATUS, 32'h77, 32'h42);
    m.xfer({8'hC3, 1'b1}, bi);
    rd(`ISS_ADDR_STATUS, 32'h77, 32'h44);
    rd(`ISS_ADDR_DATA, 32'hFF, 32'hC3);
    // Repeated start, read from the second address
    apb(1'b1, `ISS_ADDR_CONTROL, 32'h1);
    apb(1'b1, `ISS_ADDR_IRQ_CLEAR, 32'h3F);
    apb(1'b1, `ISS_ADDR_DATA, 32'h96);
    m.start;
    m.xfer({7'h3A, 2'b11}, bi);
    chk(bi[0], 1'b0);
    m.xfer(9'h1FF, bi);
    chk(bi[8:1], 8'h96);
    rd(`ISS_ADDR_STATUS, 32'h59, 32'h59);
    chk(irq, 1'b1);
    chk(which_address_matched, 1'b1);
    chk(transmitting, 1'b1);
    // MSB one, so the resend after the last NACK leaves SDA free for STOP
    apb(1'b1, `ISS_ADDR_DATA, 32'hE9);
    rd(`ISS_ADDR_STATUS, 32'h08, 32'h0);
    m.xfer(9'h1FE, bi);
    chk(bi[8:1], 8'h96);
    rd(`ISS_ADDR_STATUS, 32'h01, 32'h0);
    m.xfer(9'h1FF, bi);
    chk(bi[8:1], 8'hE9);
    rd(`ISS_ADDR_STATUS, 32'h01, 32'h01);
    apb(1'b1, `ISS_ADDR_STATUS, 32'h01);
    rd(`ISS_ADDR_STATUS, 32'h01, 32'h0);
    m.stop;
    rd(`ISS_ADDR_STATUS, 32'hA0, 32'hA0);
    apb(1'b1, `ISS_ADDR_STATUS, 32'hF0);
    rd(`ISS_ADDR_STATUS, 32'hF0, 32'h0);
    report_and_stop;
  end
endmodule // iss_slave_tb
